// >>> rtl/result_pkg.sv
// Constants shared by the result readout block: register map, status bit
// positions, reset values and the target bus address.
// Assumes a single 100 MHz clock domain with synchronous active-high reset.
package result_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h13;
   localparam logic [7:0] ADDR_CLEAR_LOW = 8'h14;
   localparam logic [7:0] ADDR_CLEAR_HIGH = 8'h15;
   localparam logic [7:0] ADDR_RED_LOW = 8'h16;
   localparam logic [7:0] ADDR_RED_HIGH = 8'h17;
   localparam logic [7:0] ADDR_GREEN_LOW = 8'h18;
   localparam logic [7:0] ADDR_GREEN_HIGH = 8'h19;
   localparam logic [7:0] ADDR_BLUE_LOW = 8'h1A;
   localparam logic [7:0] ADDR_BLUE_HIGH = 8'h1B;
   localparam logic [7:0] ADDR_NEAR_LOW = 8'h1C;
   localparam logic [7:0] ADDR_NEAR_HIGH = 8'h1D;

   // Channel order: clear, red, green, blue, near
   localparam int CHANNELS = 5;
   localparam logic [7:0] RESULT_LOW_ADDR [0:CHANNELS-1] = '{
      ADDR_CLEAR_LOW, ADDR_RED_LOW, ADDR_GREEN_LOW, ADDR_BLUE_LOW, ADDR_NEAR_LOW};
   localparam logic [7:0] RESULT_HIGH_ADDR [0:CHANNELS-1] = '{
      ADDR_CLEAR_HIGH, ADDR_RED_HIGH, ADDR_GREEN_HIGH, ADDR_BLUE_HIGH, ADDR_NEAR_HIGH};

   // ***************************************************************
   // Status fields and reset values
   // ***************************************************************
   localparam int BIT_NEAR_IRQ_FLAG = 5;
   localparam int BIT_CLEAR_CHAN_IRQ_FLAG = 4;
   localparam int BIT_NEAR_CYCLE_DONE = 1;
   localparam int BIT_COLOR_CYCLE_DONE = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ***************************************************************
   // Serial target port
   // ***************************************************************
   // Arbitrary target address
   localparam logic [6:0] TARGET_ADDR = 7'h2A;
   localparam int CMD_ADDR_MSB = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : result_pkg

// >>> rtl/reg_read_if.sv
// Read port between the serial target and the result register file.
// Assumes both ends share one clock; strobe is a one-cycle pulse.
`timescale 1ns/100ps
interface reg_read_if;
   logic strobe;
   logic [7:0] addr;
   logic [7:0] data;

   modport ctrl (output strobe, output addr, input data);
   modport regs (input strobe, input addr, output data);
endinterface : reg_read_if

// >>> rtl/result_regs.sv
// Result register file: status byte, five 16-bit results and their
// high-byte shadow copies. Assumes results come from logic on the same clock.
`timescale 1ns/100ps
module result_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Read port
   reg_read_if.regs rd,
   // Block state
   input wire logic [7:0] status,
   input wire logic [result_pkg::CHANNELS-1:0][15:0] result
);

   logic [result_pkg::CHANNELS-1:0][7:0] lane_data;
   logic [result_pkg::CHANNELS-1:0] lane_hit;

   // ***************************************************************
   // Per-channel shadow and read lane
   // ***************************************************************
   genvar i;
   generate
      for (i = 0; i < result_pkg::CHANNELS; i++) begin : g_chan
         logic [7:0] shadow_ff;
         logic low_hit;
         logic high_hit;
         assign low_hit = (rd.addr == result_pkg::RESULT_LOW_ADDR[i]);
         assign high_hit = (rd.addr == result_pkg::RESULT_HIGH_ADDR[i]);
         // Upper byte frozen at the low-byte read
         always_ff @(posedge clk) begin // see (R7) see (R13) see (R10)
            if (reset) begin
               shadow_ff <= result_pkg::SHADOW_RESET;
            end else if (rd.strobe && low_hit) begin
               shadow_ff <= result[i][15:8];
            end
         end
         assign lane_hit[i] = low_hit | high_hit;
         // High byte returns the shadow, never the live value
         assign lane_data[i] = low_hit ? result[i][7:0] : shadow_ff; // see (R8) see (R9)
      end
   endgenerate

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   always_comb begin // see (R6) see (R11)
      rd.data = result_pkg::UNMAPPED_DATA;
      if (rd.addr == result_pkg::ADDR_DEVICE_STATUS) begin
         rd.data = status;
      end
      for (int k = 0; k < result_pkg::CHANNELS; k++) begin
         if (lane_hit[k]) begin
            rd.data = lane_data[k];
         end
      end
   end

endmodule // result_regs

// >>> rtl/color_prox_result_readout.sv
// Result readout section of a colour and proximity light sensor: status
// flags, result registers and the serial target port that reads them.
// Assumes SCL/SDA come from pins (open drain, external pull-up) and the
// measurement engine runs on CLK.
//
// Contract
// (R1) Status byte: bit5 near irq, bit4 clear irq, bits1:0 cycle done, rest zero.
// (R2) Status is read only, ignores writes, resets to all zeros.
// (R3) Bit 1 sets when a near cycle ends after enable; zero before.
// (R4) Bit 0 sets when a colour cycle ends after enable; zero before.
// (R5) Clear, red, green, blue results are 16-bit unsigned values.
// (R6) Colour results sit at 0x14..0x1B, clear red green blue, low first.
// (R7) Reading a low byte copies that channel's upper byte into a shadow.
// (R8) Reading the high byte returns the shadow, not the live value.
// (R9) High byte stays matched to the low byte despite later conversions.
// (R10) Near result is 16 bits with the same shadow capture.
// (R11) Near low byte at 0x1C, high byte at 0x1D.
// (R12) Host should read each word in one two-byte read, low first.
// (R13) One shadow per channel holds the latest low-read upper byte.
`timescale 1ns/100ps
module color_prox_result_readout (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial target pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Measurement engine
   input wire logic COLOR_MEASURE_ENABLE,
   input wire logic NEAR_MEASURE_ENABLE,
   input wire logic COLOR_CYCLE_END,
   input wire logic NEAR_CYCLE_END,
   input wire logic NEAR_IRQ_FLAG,
   input wire logic CLEAR_CHAN_IRQ_FLAG,
   input wire logic [15:0] CLEAR_RESULT,
   input wire logic [15:0] RED_RESULT,
   input wire logic [15:0] GREEN_RESULT,
   input wire logic [15:0] BLUE_RESULT,
   input wire logic [15:0] NEAR_RESULT
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
      ST_WSKIP, ST_ACK_W, ST_READ, ST_ACK_READ
   } target_state_t;

   target_state_t state_ff;
   logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
   logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] ptr_ff;
   logic rw_ff;
   logic oe_ff;
   logic nack_ff;
   logic color_done_ff, near_done_ff, near_irq_ff, clear_irq_ff;
   logic [7:0] status_byte;
   logic [result_pkg::CHANNELS-1:0][15:0] result_bus;
   logic load_byte;

   reg_read_if rd_bus ();

   // ***************************************************************
   // Pin synchronisers and bus conditions
   // ***************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         scl_meta_ff <= 1'b1;
         scl_sync_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_meta_ff <= 1'b1;
         sda_sync_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_meta_ff <= SCL_IN;
         scl_sync_ff <= scl_meta_ff;
         scl_prev_ff <= scl_sync_ff;
         sda_meta_ff <= SDA_IN;
         sda_sync_ff <= sda_meta_ff;
         sda_prev_ff <= sda_sync_ff;
      end
   end

   assign scl_rise = scl_sync_ff & ~scl_prev_ff;
   assign scl_fall = ~scl_sync_ff & scl_prev_ff;
   assign bus_start = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
   assign bus_stop = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

   // ***************************************************************
   // Status flags
   // ***************************************************************
   // Cycle-done flags clear while the enable is low
   always_ff @(posedge CLK) begin
      if (RESET) begin
         color_done_ff <= 1'b0;
      end else if (!COLOR_MEASURE_ENABLE) begin
         color_done_ff <= 1'b0;
      end else if (COLOR_CYCLE_END) begin
         color_done_ff <= 1'b1; // see (R4)
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         near_done_ff <= 1'b0;
      end else if (!NEAR_MEASURE_ENABLE) begin
         near_done_ff <= 1'b0;
      end else if (NEAR_CYCLE_END) begin
         near_done_ff <= 1'b1; // see (R3)
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         near_irq_ff <= 1'b0;
         clear_irq_ff <= 1'b0;
      end else begin
         near_irq_ff <= NEAR_IRQ_FLAG;
         clear_irq_ff <= CLEAR_CHAN_IRQ_FLAG;
      end
   end

   always_comb begin // see (R1) see (R2)
      status_byte = result_pkg::STATUS_RESET;
      status_byte[result_pkg::BIT_NEAR_IRQ_FLAG] = near_irq_ff;
      status_byte[result_pkg::BIT_CLEAR_CHAN_IRQ_FLAG] = clear_irq_ff;
      status_byte[result_pkg::BIT_NEAR_CYCLE_DONE] = near_done_ff;
      status_byte[result_pkg::BIT_COLOR_CYCLE_DONE] = color_done_ff;
   end

   // ***************************************************************
   // Register file
   // ***************************************************************
   assign result_bus = {NEAR_RESULT, BLUE_RESULT, GREEN_RESULT, RED_RESULT, CLEAR_RESULT}; // see (R5)

   result_regs u_regs (
      .clk(CLK),
      .reset(RESET),
      .rd(rd_bus.regs),
      .status(status_byte),
      .result(result_bus)
   );

   // A byte is fetched on the SCL fall that starts each data byte of a read
   assign load_byte = scl_fall &&
      ((state_ff == ST_ACK_ADDR && rw_ff) || (state_ff == ST_ACK_READ && !nack_ff));
   assign rd_bus.strobe = load_byte;
   assign rd_bus.addr = ptr_ff;

   // ***************************************************************
   // Serial target state machine
   // ***************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         rw_ff <= 1'b0;
         oe_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else if (bus_start) begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         oe_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= ST_IDLE;
         oe_ff <= 1'b0;
      end else if (scl_rise) begin
         case (state_ff)
            ST_ADDR, ST_CMD, ST_WSKIP, ST_READ: begin
               shift_ff <= {shift_ff[6:0], sda_sync_ff};
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            ST_ACK_READ: begin
               nack_ff <= sda_sync_ff;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR: begin
               if (bit_cnt_ff == result_pkg::BITS_PER_BYTE) begin
                  if (shift_ff[7:1] == result_pkg::TARGET_ADDR) begin
                     rw_ff <= shift_ff[0];
                     oe_ff <= 1'b1;
                     state_ff <= ST_ACK_ADDR;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_READ: begin
               bit_cnt_ff <= 4'h0;
               if (load_byte) begin
                  tx_ff <= rd_bus.data;
                  oe_ff <= ~rd_bus.data[7];
                  ptr_ff <= ptr_ff + 8'h01;
                  state_ff <= ST_READ;
               end else if (state_ff == ST_ACK_ADDR) begin
                  oe_ff <= 1'b0;
                  state_ff <= ST_CMD;
               end else begin
                  oe_ff <= 1'b0;
                  state_ff <= ST_IDLE;
               end
            end
            ST_CMD: begin
               if (bit_cnt_ff == result_pkg::BITS_PER_BYTE) begin
                  ptr_ff <= {3'h0, shift_ff[result_pkg::CMD_ADDR_MSB:0]};
                  oe_ff <= 1'b1;
                  state_ff <= ST_ACK_CMD;
               end
            end
            ST_WSKIP: begin
               // Written data is acknowledged and dropped
               if (bit_cnt_ff == result_pkg::BITS_PER_BYTE) begin
                  oe_ff <= 1'b1; // see (R2)
                  state_ff <= ST_ACK_W;
               end
            end
            ST_ACK_CMD, ST_ACK_W: begin
               oe_ff <= 1'b0;
               bit_cnt_ff <= 4'h0;
               state_ff <= ST_WSKIP;
            end
            ST_READ: begin
               if (bit_cnt_ff == result_pkg::BITS_PER_BYTE) begin
                  oe_ff <= 1'b0;
                  nack_ff <= 1'b0;
                  state_ff <= ST_ACK_READ;
               end else begin
                  oe_ff <= ~tx_ff[3'(7 - bit_cnt_ff)];
               end
            end
            default: begin
               oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign SDA_OUT = 1'b0;
   assign SDA_OE = oe_ff;

endmodule // color_prox_result_readout

// >>> bench/readout_props.sv
// Pin-level checks on the serial data output of the result readout.
// Bound to the top module; a released data pin idles high.
`timescale 1ns/100ps
module readout_props (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial pins
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   // Engine
   input wire logic COLOR_CYCLE_END
);
   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);

   property p_rst;
      $fell(RESET) |-> !SDA_OE [*3];
   endproperty
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   property p_od;
      SDA_OUT == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_low;
      $changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2);
   endproperty
   a_low: assert property (p_low) else $error("pin changed near clock high");
   property p_high;
      SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE);
   endproperty
   a_high: assert property (p_high) else $error("pin changed in clock high");
   property p_gap;
      $fell(SCL_IN) |=> $stable(SDA_OE) [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("pin changed too early");
   property p_bit;
      $rose(SDA_OE) |=> SDA_OE [*8];
   endproperty
   a_bit: assert property (p_bit) else $error("low bit too short");
   property p_rel;
      $fell(SDA_OE) |=> !SDA_OE [*8];
   endproperty
   a_rel: assert property (p_rel) else $error("high bit too short");
   property p_set;
      $fell(SCL_IN) |-> ##6 $stable(SDA_OE) [*4];
   endproperty
   a_set: assert property (p_set) else $error("pin not settled");

   c_drive: cover property ($rose(SDA_OE));
   c_end: cover property (COLOR_CYCLE_END);
   c_hold: cover property ($fell(SCL_IN) ##1 SDA_OE);
endmodule // readout_props
bind color_prox_result_readout readout_props u_props (.CLK(CLK), .RESET(RESET),
   .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .COLOR_CYCLE_END(COLOR_CYCLE_END));

// >>> bench/i2c_host_model.sv
// Behavioural bus controller that reads the result registers.
// Assumes a pull-up: the wire is high unless some party pulls it low.
`timescale 1ns/100ps
module i2c_host_model (
   // Bus pins
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // One bit: data moves mid low phase, sampled mid high phase
   task automatic slot(input logic b, output logic r);
      #30 sda_low = !b;
      #32.5 scl = 1'b1;
      #30 r = sda;
      #32.5 scl = 1'b0;
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start();
      #30 sda_low = 1'b0;
      #32.5 scl = 1'b1;
      #30 sda_low = 1'b1;
      #32.5 scl = 1'b0;
   endtask
   task automatic stop();
      #30 sda_low = 1'b1;
      #32.5 scl = 1'b1;
      #30 sda_low = 1'b0;
      #32.5;
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         slot(d[i], r);
      end
      slot(1'b1, r);
      ack = !r;
   endtask
   // Last byte of a word read is refused so the target lets go
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         slot(1'b1, r);
         d[i] = r;
      end
      slot(last, r);
   endtask
endmodule // i2c_host_model

// >>> bench/testbench.sv
// Self-checking bench for the result readout block through its serial port.
// Assumes the host model drives the bus pins and results change between reads.
`timescale 1ns/100ps
module testbench;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic cen = 1'b0, nen = 1'b0, cend = 1'b0, nend = 1'b0, nirq = 1'b0, cirq = 1'b0;
   logic [15:0] res [5] = '{default: 16'h0000};
   logic scl, sda_low, sda_oe, sda_out;
   wire logic sda = !(sda_oe | sda_low);
   int n_fail = 0, compares = 0, cyc = 0;

   i2c_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
   color_prox_result_readout dut (.CLK(CLK), .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .COLOR_MEASURE_ENABLE(cen),
      .NEAR_MEASURE_ENABLE(nen), .COLOR_CYCLE_END(cend), .NEAR_CYCLE_END(nend),
      .NEAR_IRQ_FLAG(nirq), .CLEAR_CHAN_IRQ_FLAG(cirq), .CLEAR_RESULT(res[0]),
      .RED_RESULT(res[1]), .GREEN_RESULT(res[2]), .BLUE_RESULT(res[3]),
      .NEAR_RESULT(res[4]));

   initial begin
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         $display("MISMATCH t=%0t timeout", $time);
         n_fail++;
         report_and_stop();
      end
   end

   // ********************
   // Tasks
   // ********************
   task automatic step(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Acknowledge bits of the bytes sent, one per byte
   task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t ack %b exp %b", $time, got, exp);
      end
   endtask
   // s = {near irq, clear irq, near enable, colour enable, near end, colour end}
   function automatic logic [7:0] exp_status(input logic [5:0] s);
      return {2'b00, s[5], s[4], 2'b00, s[3] & s[1], s[2] & s[0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k0, k1, k2;
      host.start();
      host.put({result_pkg::TARGET_ADDR, 1'b0}, k0);
      host.put(a, k1);
      host.put(d, k2);
      host.stop();
      step(1);
      chk_ack({k0, k1, k2}, 3'h7);
   endtask
   task automatic rd(input logic [7:0] a, input int n, output logic [15:0] w);
      logic k0, k1, k2;
      host.start();
      host.put({result_pkg::TARGET_ADDR, 1'b0}, k0);
      // Upper command bits are don't-care for the pointer
      host.put({3'($urandom), a[4:0]}, k1);
      host.start();
      host.put({result_pkg::TARGET_ADDR, 1'b1}, k2);
      host.get(n == 1, w[7:0]);
      if (n == 2) begin
         host.get(1'b1, w[15:8]);
      end
      host.stop();
      step(1);
      chk_ack({k0, k1, k2}, 3'h7);
   endtask
   task automatic report_and_stop();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      logic [15:0] w;
      logic [7:0] hold;
      logic [5:0] s;
      logic k;
      void'($urandom(32'h0000_c377));
      step(3);
      RESET = 1'b0;
      step(3);
      for (int i = 0; i < 8; i++) begin
         s = (i == 0) ? 6'h3f : 6'($urandom);
         {cen, nen, cend, nend} = 4'b0011;
         step(1);
         {cend, nend} = 2'b00;
         {nirq, cirq, nen, cen} = s[5:2];
         step(1);
         {nend, cend} = s[1:0];
         step(1);
         {nend, cend} = 2'b00;
         wr(result_pkg::ADDR_DEVICE_STATUS, 8'hFF);
         rd(result_pkg::ADDR_DEVICE_STATUS, 1, w);
         chk(w[7:0], exp_status(s));
      end
      for (int c = 0; c < result_pkg::CHANNELS; c++) begin
         res[c] = 16'($urandom);
         rd(result_pkg::RESULT_LOW_ADDR[c], 2, w);
         chk(w[7:0], res[c][7:0]);
         chk(w[15:8], res[c][15:8]);
         res[c] = 16'($urandom);
         hold = res[c][15:8];
         rd(result_pkg::RESULT_LOW_ADDR[c], 1, w);
         res[c] = ~res[c];
         res[(c + 1) % 5] = 16'($urandom);
         rd(result_pkg::RESULT_LOW_ADDR[(c + 1) % 5], 1, w);
         rd(result_pkg::RESULT_HIGH_ADDR[c], 1, w);
         chk(w[7:0], hold);
      end
      {nirq, cirq, nen, cen} = 4'h0;
      RESET = 1'b1;
      step(3);
      RESET = 1'b0;
      step(3);
      for (int c = 0; c < result_pkg::CHANNELS; c++) begin
         rd(result_pkg::RESULT_HIGH_ADDR[c], 1, w);
         chk(w[7:0], result_pkg::SHADOW_RESET);
      end
      rd(result_pkg::ADDR_DEVICE_STATUS, 1, w);
      chk(w[7:0], result_pkg::STATUS_RESET);
      rd(8'h1E, 1, w);
      chk(w[7:0], result_pkg::UNMAPPED_DATA);
      host.start();
      host.put({~result_pkg::TARGET_ADDR, 1'b0}, k);
      host.stop();
      step(1);
      chk_ack({2'b00, k}, 3'h0);
      report_and_stop();
   end
endmodule // testbench
